/* pkg/gp_event_pkg.sv */
`default_nettype none

package gp_event_pkg;

  // ----------------------------------------------------------------
  // Configuration space offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] EVENT_STATUS_OFFSET = 8'h88;
  localparam logic [7:0] EVENT_ENABLE_OFFSET = 8'h89;
  localparam logic [7:0] INPUT_LEVELS_OFFSET = 8'h8A;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int POWER_CHANGE_BIT  = 7;
  localparam int HIGH_VPP_BIT      = 6;
  localparam int RESERVED_BIT      = 5;
  localparam int INPUT_COUNT       = 5;

  // ----------------------------------------------------------------
  // Reset values and field masks
  // ----------------------------------------------------------------
  localparam logic [7:0] EVENT_STATUS_RESET = 8'h00;
  localparam logic [7:0] EVENT_ENABLE_RESET = 8'h00;
  localparam logic [7:0] EVENT_BITS_MASK    = 8'hDF;
  localparam logic [7:0] INPUT_LEVELS_MASK  = 8'h1F;
  localparam logic [7:0] READ_ZERO          = 8'h00;

  // ----------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------
  localparam int          SYNC_STAGES   = 2;
  localparam logic [1:0]  ARM_CYCLES    = 2'h3;

  // ----------------------------------------------------------------
  // Configuration access carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       rdEn;
    logic       wrEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } cfg_req_t;

endpackage

`default_nettype wire

/* rtl/input_change_detect.sv */
`default_nettype none

module input_change_detect
(
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic pinAsync,
  input  wire logic armed,
  output var  logic level,
  output var  logic changed
);

  logic syncFirst_q;
  logic syncSecond_q;
  logic prevLevel_q;

  // ----------------------------------------------------------------
  // Synchroniser and change detector
  // ----------------------------------------------------------------
  // The first stage feeds only the second stage, so metastability
  // never reaches the comparator.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      syncFirst_q  <= 1'b0;
      syncSecond_q <= 1'b0;
      prevLevel_q  <= 1'b0;
    end
    else
    begin
      syncFirst_q  <= pinAsync;
      syncSecond_q <= syncFirst_q;
      prevLevel_q  <= syncSecond_q;
    end
  end

  assign level   = syncSecond_q;
  assign changed = armed & (syncSecond_q ^ prevLevel_q);

endmodule

`default_nettype wire

/* rtl/gp_event_and_input_logic.sv */
`default_nettype none

module gp_event_and_input_logic
(
  input  wire logic                     sys_clk,
  input  wire logic                     reset_n,
  input  wire gp_event_pkg::cfg_req_t   cfgReq,
  input  wire logic                     powerStateChange,
  input  wire logic                     highVppChange,
  input  wire logic [4:0]               pinIsInput,
  input  wire logic                     multiPinFive,
  input  wire logic                     multiPinFour,
  input  wire logic                     multiPinTwo,
  input  wire logic                     multiPinOne,
  input  wire logic                     multiPinZero,
  output var  logic [7:0]               cfgRdData,
  output var  logic                     cfgRdValid,
  output var  logic                     eventWakeOut
);
  import gp_event_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [INPUT_COUNT-1:0] pinRaw;
  logic [INPUT_COUNT-1:0] pinLevel;
  logic [INPUT_COUNT-1:0] pinChanged;
  logic [1:0]             armCount_q;
  logic [1:0]             armCount_d;
  logic                   armed;
  logic [7:0]             status_q;
  logic [7:0]             status_d;
  logic [7:0]             enable_q;
  logic [7:0]             enable_d;
  logic [7:0]             setVec;
  logic [7:0]             clrVec;
  logic [7:0]             levelsView;
  logic [7:0]             readMux;
  logic                   wrStatus;
  logic                   wrEnable;
  logic                   hitStatus;
  logic                   hitEnable;
  logic                   hitLevels;
  logic                   eventAny;
  logic [7:0]             cfgRdData_q;
  logic                   cfgRdValid_q;
  logic                   eventWakeOut_q;

  // ----------------------------------------------------------------
  // Terminal inputs
  // ----------------------------------------------------------------
  assign pinRaw = {multiPinFive, multiPinFour, multiPinTwo, multiPinOne, multiPinZero};

  genvar gi;
  generate
    for (gi = 0; gi < INPUT_COUNT; gi++)
    begin : g_input
      input_change_detect u_detect
      (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .pinAsync (pinRaw[gi]),
        .armed    (armed),
        .level    (pinLevel[gi]),
        .changed  (pinChanged[gi])
      );
    end
  endgenerate

  // Detectors stay disarmed until the synchronisers hold real pin levels,
  // otherwise a pin that is high at reset release would look like an edge.
  assign armed      = (armCount_q == ARM_CYCLES);
  assign armCount_d = armed ? armCount_q : armCount_q + 2'h1;

  // ----------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------
  assign hitStatus = (cfgReq.addr == EVENT_STATUS_OFFSET);
  assign hitEnable = (cfgReq.addr == EVENT_ENABLE_OFFSET);
  assign hitLevels = (cfgReq.addr == INPUT_LEVELS_OFFSET);
  assign wrStatus  = cfgReq.wrEn & hitStatus;
  assign wrEnable  = cfgReq.wrEn & hitEnable;

  // ----------------------------------------------------------------
  // Event status and enable
  // ----------------------------------------------------------------
  assign setVec[POWER_CHANGE_BIT]  = powerStateChange;
  assign setVec[HIGH_VPP_BIT]      = highVppChange;
  assign setVec[RESERVED_BIT]      = 1'b0;
  assign setVec[INPUT_COUNT-1:0]   = pinChanged & pinIsInput;
  assign clrVec   = wrStatus ? cfgReq.wrData : READ_ZERO;
  // A new event in the clearing cycle wins, so no event is ever lost.
  assign status_d = ((status_q & ~clrVec) | setVec) & EVENT_BITS_MASK;
  assign enable_d = wrEnable ? (cfgReq.wrData & EVENT_BITS_MASK) : enable_q;
  assign eventAny = |(status_q & enable_q);

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  assign levelsView = {3'h0, pinLevel} & INPUT_LEVELS_MASK;
  assign readMux    = hitStatus ? status_q :
                      hitEnable ? enable_q :
                      hitLevels ? levelsView : READ_ZERO;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Only the global reset reaches these flops; function resets do not.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      status_q       <= EVENT_STATUS_RESET;
      enable_q       <= EVENT_ENABLE_RESET;
      armCount_q     <= 2'h0;
      cfgRdData_q    <= READ_ZERO;
      cfgRdValid_q   <= 1'b0;
      eventWakeOut_q <= 1'b0;
    end
    else
    begin
      status_q       <= status_d;
      enable_q       <= enable_d;
      armCount_q     <= armCount_d;
      cfgRdData_q    <= cfgReq.rdEn ? readMux : READ_ZERO;
      cfgRdValid_q   <= cfgReq.rdEn;
      eventWakeOut_q <= eventAny;
    end
  end

  assign cfgRdData    = cfgRdData_q;
  assign cfgRdValid   = cfgRdValid_q;
  assign eventWakeOut = eventWakeOut_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_power_set;
    @(posedge sys_clk) disable iff (!reset_n)
    powerStateChange |=> status_q[7];
  endproperty
  a_power_set: assert property (p_power_set)
    else $error("Power change flag not set after power change.");

  property p_vpp_set;
    @(posedge sys_clk) disable iff (!reset_n)
    highVppChange |=> status_q[6];
  endproperty
  a_vpp_set: assert property (p_vpp_set)
    else $error("High Vpp flag not set after Vpp change.");

  property p_reserved_zero;
    @(posedge sys_clk) disable iff (!reset_n)
    cfgReq.wrEn |=> (status_q[5] == 1'b0) && (enable_q[5] == 1'b0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("Reserved bit 5 became set.");

  property p_input_set;
    @(posedge sys_clk) disable iff (!reset_n)
    armed && $changed(pinLevel[4]) && pinIsInput[4] |=> status_q[4];
  endproperty
  a_input_set: assert property (p_input_set)
    else $error("Input four change did not set its flag.");

  property p_inputs_low_set;
    @(posedge sys_clk) disable iff (!reset_n)
    |(pinChanged[3:0] & pinIsInput[3:0]) |=>
      ((status_q[3:0] & $past(pinChanged[3:0] & pinIsInput[3:0]))
        == $past(pinChanged[3:0] & pinIsInput[3:0]));
  endproperty
  a_inputs_low_set: assert property (p_inputs_low_set)
    else $error("Low input change did not set its flag.");

  property p_unconfigured_quiet;
    @(posedge sys_clk) disable iff (!reset_n)
    !status_q[0] && !pinIsInput[0] |=> !status_q[0];
  endproperty
  a_unconfigured_quiet: assert property (p_unconfigured_quiet)
    else $error("Flag set for terminal not configured as input.");

  property p_sticky;
    @(posedge sys_clk) disable iff (!reset_n)
    status_q[7] && !(wrStatus && cfgReq.wrData[7]) |=> status_q[7];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("Power flag dropped without a clearing write.");

  property p_clear;
    @(posedge sys_clk) disable iff (!reset_n)
    wrStatus && cfgReq.wrData[7] && !powerStateChange |=> !status_q[7];
  endproperty
  a_clear: assert property (p_clear)
    else $error("Power flag not cleared by written one.");

  property p_event_on;
    @(posedge sys_clk) disable iff (!reset_n)
    (status_q[7] && enable_q[7]) || (status_q[6] && enable_q[6]) |=> eventWakeOut;
  endproperty
  a_event_on: assert property (p_event_on)
    else $error("Event output missing for enabled power flag.");

  property p_event_match;
    @(posedge sys_clk) disable iff (!reset_n)
    ##1 eventWakeOut == $past(|(status_q[4:0] & enable_q[4:0]) || status_q[7] && enable_q[7]
                              || status_q[6] && enable_q[6]);
  endproperty
  a_event_match: assert property (p_event_match)
    else $error("Event output differs from enabled flags.");

  property p_levels_read;
    @(posedge sys_clk) disable iff (!reset_n)
    cfgReq.rdEn && hitLevels |=>
      cfgRdValid && cfgRdData == {3'h0, $past(pinLevel)};
  endproperty
  a_levels_read: assert property (p_levels_read)
    else $error("Input register read wrong value.");

  property p_unmapped_zero;
    @(posedge sys_clk) disable iff (!reset_n)
    cfgReq.rdEn && !hitStatus && !hitEnable && !hitLevels |=> cfgRdData == 8'h00;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("Unmapped read returned nonzero data.");

  property p_power_quiet;
    @(posedge sys_clk) disable iff (!reset_n)
    !status_q[7] && !powerStateChange |=> !status_q[7];
  endproperty
  a_power_quiet: assert property (p_power_quiet)
    else $error("Power change flag set with no power change.");

  property p_vpp_quiet;
    @(posedge sys_clk) disable iff (!reset_n)
    !status_q[6] && !highVppChange |=> !status_q[6];
  endproperty
  a_vpp_quiet: assert property (p_vpp_quiet)
    else $error("High Vpp flag set with no Vpp change.");

  property p_input4_quiet;
    @(posedge sys_clk) disable iff (!reset_n)
    !status_q[4] && !pinIsInput[4] |=> !status_q[4];
  endproperty
  a_input4_quiet: assert property (p_input4_quiet)
    else $error("Input four flag set while not configured as input.");

  property p_set_wins;
    @(posedge sys_clk) disable iff (!reset_n)
    wrStatus && cfgReq.wrData[7] && powerStateChange |=> status_q[7];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("Power event lost against a clearing write.");

  property p_enable_write;
    @(posedge sys_clk) disable iff (!reset_n)
    wrEnable |=> enable_q == ($past(cfgReq.wrData) & EVENT_BITS_MASK);
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("Enable register did not take the written value.");

  property p_enable_hold;
    @(posedge sys_clk) disable iff (!reset_n)
    !wrEnable |=> $stable(enable_q);
  endproperty
  a_enable_hold: assert property (p_enable_hold)
    else $error("Enable register changed without a write.");

  property p_event_off;
    @(posedge sys_clk) disable iff (!reset_n)
    !eventAny |=> !eventWakeOut;
  endproperty
  a_event_off: assert property (p_event_off)
    else $error("Event output high with no enabled flag.");

  property p_read_answer;
    @(posedge sys_clk) disable iff (!reset_n)
    cfgReq.rdEn |=> cfgRdValid;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("Read request got no valid answer.");

  property p_status_read;
    @(posedge sys_clk) disable iff (!reset_n)
    cfgReq.rdEn && hitStatus |=> cfgRdData == $past(status_q);
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("Status read returned wrong value.");

  c_event_raised: cover property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(eventWakeOut));
  c_set_and_clear: cover property (@(posedge sys_clk) disable iff (!reset_n)
    wrStatus && cfgReq.wrData[7] && powerStateChange);
  c_input_flag: cover property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(status_q[2]));

endmodule

`default_nettype wire

/* test/pin_source.sv */
`default_nettype none

module pin_source
(
  input  wire logic [4:0] target,
  output var  logic       multiPinFive,
  output var  logic       multiPinFour,
  output var  logic       multiPinTwo,
  output var  logic       multiPinOne,
  output var  logic       multiPinZero
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [4:0] pinLevel;

  // ----------------------------------------------------------------
  // Terminal drive
  // ----------------------------------------------------------------
  // The terminals move 37 ns after a request so that edges never line up with the clock.
  initial pinLevel = 5'h00;
  always @(target) pinLevel <= #37 target;

  assign multiPinFive = pinLevel[4];
  assign multiPinFour = pinLevel[3];
  assign multiPinTwo  = pinLevel[2];
  assign multiPinOne  = pinLevel[1];
  assign multiPinZero = pinLevel[0];
endmodule

`default_nettype wire

/* test/tb_gp_event_and_input_logic.sv */
`default_nettype none

module tb_gp_event_and_input_logic;
  timeunit 1ns;
  timeprecision 1ns;
  import gp_event_pkg::*;

  logic       sys_clk = 1'b0;
  logic       reset_n = 1'b0;
  cfg_req_t   cfgReq = '0;
  logic       powerStateChange = 1'b0;
  logic       highVppChange = 1'b0;
  logic [4:0] pinIsInput = 5'h00;
  logic [4:0] pinTarget = 5'h00;
  wire logic  mp5, mp4, mp2, mp1, mp0;
  logic [7:0] cfgRdData;
  logic       cfgRdValid;
  logic       eventWakeOut;
  logic [7:0] expQ[$];
  logic [31:0] lfsrState = 32'ha6fd_047c;
  int         fails = 0;
  int         n_tests = 0;
  int         cycles = 0;

  always #50 sys_clk = ~sys_clk;

  gp_event_and_input_logic uut (.sys_clk(sys_clk), .reset_n(reset_n), .cfgReq(cfgReq),
    .powerStateChange(powerStateChange), .highVppChange(highVppChange),
    .pinIsInput(pinIsInput), .multiPinFive(mp5), .multiPinFour(mp4), .multiPinTwo(mp2),
    .multiPinOne(mp1), .multiPinZero(mp0), .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid),
    .eventWakeOut(eventWakeOut));

  pin_source pins (.target(pinTarget), .multiPinFive(mp5), .multiPinFour(mp4),
    .multiPinTwo(mp2), .multiPinOne(mp1), .multiPinZero(mp0));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr();
    lfsrState = (lfsrState >> 1) ^ (lfsrState[0] ? 32'h8020_0003 : 32'h0000_0000);
    return lfsrState;
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    cfgReq.rdEn = 1'b1;
    cfgReq.addr = a;
    expQ.push_back(e);
    step(1);
    cfgReq.rdEn = 1'b0;
    // An idle cycle keeps back-to-back calls from re-driving the strobe in one step.
    step(1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cfgReq.wrEn = 1'b1;
    cfgReq.addr = a;
    cfgReq.wrData = d;
    step(1);
    cfgReq.wrEn = 1'b0;
    step(1);
  endtask

  task automatic check_wake(input logic e);
    n_tests++;
    if (eventWakeOut !== e)
    begin
      fails++;
      $display("[ERR] %0t wake output %b, expected %b", $time, eventWakeOut, e);
    end
  endtask

  // Read answers are matched in order; a stray answer with nothing queued is a mismatch.
  always @(negedge sys_clk)
    if (cfgRdValid === 1'b1)
    begin
      n_tests++;
      if (expQ.size() == 0 || cfgRdData !== expQ[0])
      begin
        fails++;
        $display("[ERR] %0t read data %h unexpected", $time, cfgRdData);
      end
      if (expQ.size() != 0) void'(expQ.pop_front());
    end

  task automatic finish_test();
    if (expQ.size() != 0) fails++;
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      $display("[ERR] %0t run did not finish", $time);
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic event_case(input int b);
    logic [7:0] m;
    m = 8'h01 << b;
    wr(EVENT_ENABLE_OFFSET, EVENT_BITS_MASK & ~m);
    if (b == POWER_CHANGE_BIT) powerStateChange = 1'b1;
    else highVppChange = 1'b1;
    step(1);
    powerStateChange = 1'b0;
    highVppChange = 1'b0;
    step(3);
    check_wake(1'b0);
    rd(EVENT_STATUS_OFFSET, m);
    wr(EVENT_STATUS_OFFSET, ~m);
    rd(EVENT_STATUS_OFFSET, m);
    wr(EVENT_ENABLE_OFFSET, EVENT_BITS_MASK);
    step(2);
    check_wake(1'b1);
    wr(EVENT_STATUS_OFFSET, m);
    step(2);
    check_wake(1'b0);
    rd(EVENT_STATUS_OFFSET, 8'h00);
  endtask

  initial
  begin
    logic [7:0] v;
    step(5);
    reset_n = 1'b1;
    step(4);
    rd(EVENT_STATUS_OFFSET, EVENT_STATUS_RESET);
    rd(EVENT_ENABLE_OFFSET, EVENT_ENABLE_RESET);
    rd(INPUT_LEVELS_OFFSET, 8'h00);
    rd(8'h8B, READ_ZERO);
    wr(EVENT_STATUS_OFFSET, 8'hFF);
    rd(EVENT_STATUS_OFFSET, 8'h00);
    $display("Test reset values done");
    for (int k = 0; k < 4; k++)
    begin
      v = 8'(lfsr());
      wr(EVENT_ENABLE_OFFSET, v);
      rd(EVENT_ENABLE_OFFSET, v & EVENT_BITS_MASK);
    end
    wr(EVENT_ENABLE_OFFSET, 8'hFF);
    rd(EVENT_ENABLE_OFFSET, EVENT_BITS_MASK);
    $display("Test enable access done");
    event_case(POWER_CHANGE_BIT);
    event_case(HIGH_VPP_BIT);
    $display("Test power events done");
    for (int i = 0; i < INPUT_COUNT; i++)
    begin
      pinIsInput = 5'h1F;
      pinTarget[i] = ~pinTarget[i];
      step(8);
      rd(EVENT_STATUS_OFFSET, 8'h01 << i);
      rd(INPUT_LEVELS_OFFSET, {3'b000, pinTarget});
      check_wake(1'b1);
      wr(EVENT_STATUS_OFFSET, 8'h01 << i);
      step(2);
      check_wake(1'b0);
      pinIsInput[i] = 1'b0;
      pinTarget[i] = ~pinTarget[i];
      step(8);
      rd(EVENT_STATUS_OFFSET, 8'h00);
    end
    $display("Test input changes done");
    pinIsInput = 5'h00;
    pinTarget = 5'(lfsr());
    step(8);
    wr(INPUT_LEVELS_OFFSET, 8'hFF);
    rd(INPUT_LEVELS_OFFSET, {3'b000, pinTarget} & INPUT_LEVELS_MASK);
    rd(EVENT_STATUS_OFFSET, 8'h00);
    $display("Test input levels done");
    powerStateChange = 1'b1;
    step(1);
    powerStateChange = 1'b0;
    step(3);
    check_wake(1'b1);
    powerStateChange = 1'b1;
    cfgReq.wrEn = 1'b1;
    cfgReq.addr = EVENT_STATUS_OFFSET;
    cfgReq.wrData = 8'h80;
    step(1);
    powerStateChange = 1'b0;
    cfgReq.wrEn = 1'b0;
    step(1);
    rd(EVENT_STATUS_OFFSET, 8'h80);
    reset_n = 1'b0;
    step(2);
    reset_n = 1'b1;
    step(2);
    check_wake(1'b0);
    rd(EVENT_STATUS_OFFSET, 8'h00);
    rd(EVENT_ENABLE_OFFSET, 8'h00);
    step(2);
    $display("Test global reset done");
    finish_test();
  end
endmodule

`default_nettype wire
